// ### design/sgmsel_top.sv
// Purpose: selects the MAC interface and runs the serial side (rate adaptation, clock lane, auto-negotiation)
// Assumes: serial line coding and serdes sit below this block; one 25 MHz clock
// Notes: bytes move on valid/ready; a two-entry buffer absorbs serialiser stalls
`timescale 1ns/1ps
// Functional notes
// R1 - The serial enable strap is loaded into the serial enable bit of the PHY control register after reset.
// R2 - Serial mode runs whenever the serial bit is set, parallel mode only when serial is clear and parallel set.
// R3 - The strapped serial enable and parallel disable values stay readable as strap status.
// R4 - Serial data runs at a fixed 1.25 Gbit/s line rate whatever the media speed.
// R5 - Transmit timing is recovered from incoming serial data, with no transmit clock from the MAC.
// R6 - By default one transmit and one receive pair are used, each with clock recovered from data.
// R7 - When configured, a receive clock is driven on an extra pair, giving a six-wire link.
// R8 - At 100 Mbit/s every frame byte is repeated ten times in succession. The code sends the start-of-frame delimiter byte once.
// R9 - Repetition happens above coding, so the start-of-frame delimiter is sent once.
// R10 - With auto-negotiation on, control words carry the media-resolved speed to the MAC.
// R11 - In MAC loopback the serial speed follows the media-side speed selection.
// R12 - In MAC loopback the serial interface keeps working with auto-negotiation on or forced speed.
// R13 - After reset serial auto-negotiation is enabled.
// R14 - With auto-negotiation off the serial speed is forced to the media-resolved speed.
// R15 - Clearing the auto-negotiation enable bit of the second configuration register disables it.
// R16 - At 10 Mbit/s the serial rate adapts automatically, without changing the rate adapt bit.
// R17 - At 1000 Mbit/s each frame byte is sent exactly once.
module sgmsel_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_enable_strap_pin,
  input wire logic parallel_disable_strap_pin,
  input wire logic phy_ctrl_wr,
  input wire logic phy_ctrl_serial_en_wdata,
  input wire logic parallel_ctrl_wr,
  input wire logic parallel_en_wdata,
  input wire logic second_cfg_wr,
  input wire logic second_cfg_autoneg_wdata,
  input wire logic second_cfg_rate_adapt_wdata,
  input wire logic rx_clk_lane_cfg,
  input wire logic mac_loopback,
  input wire sgmsel_pkg::sgmsel_media_s media_res,
  input wire sgmsel_pkg::sgmsel_speed_e loopback_speed_sel,
  input wire logic in_valid,
  output logic in_ready,
  input wire sgmsel_pkg::sgmsel_byte_s in_byte,
  output logic out_valid,
  input wire logic out_ready,
  output sgmsel_pkg::sgmsel_byte_s out_byte,
  output sgmsel_pkg::sgmsel_mode_e mode,
  output logic serial_enable_bit,
  output logic parallel_enable_bit,
  output logic serial_autoneg_enable_bit,
  output logic ten_meg_rate_adapt_bit,
  output logic strap_serial_enable,
  output logic strap_parallel_disable,
  output sgmsel_pkg::sgmsel_speed_e serial_speed,
  output logic [15:0] an_ctrl_word,
  output logic an_ctrl_valid,
  output logic rx_clk_lane_out,
  output logic rx_clk_lane_oe
);
  logic strap_s1_r, strap_s2_r, pdis_s1_r, pdis_s2_r;
  logic [1:0] settle_r;
  logic strap_done_r;
  logic strap_serial_r, strap_pdis_r;
  logic serial_en_r, parallel_en_r, an_en_r, rate_adapt_r;
  sgmsel_pkg::sgmsel_mode_e mode_nxt;
  sgmsel_pkg::sgmsel_speed_e speed_r, speed_nxt;
  sgmsel_pkg::sgmsel_byte_s buf_r [2];
  logic wr_ptr_r, rd_ptr_r;
  logic [1:0] count_r;
  logic [6:0] rep_cnt_r;
  logic push, pop, fire, last_rep;
  logic rx_clk_r;
  logic [15:0] an_word_r;

  // number of times a byte is sent at a given speed
  function automatic logic [6:0] rep_limit(input sgmsel_pkg::sgmsel_speed_e s);
    case (s)
      sgmsel_pkg::SGMSEL_SPD_10: rep_limit = sgmsel_pkg::REP_COUNT_10;
      sgmsel_pkg::SGMSEL_SPD_100: rep_limit = sgmsel_pkg::REP_COUNT_100;
      default: rep_limit = sgmsel_pkg::REP_COUNT_1000;
    endcase
  endfunction

  // two-stage synchronisers for the strap pins
  always_ff @(posedge clk) begin
    strap_s1_r <= serial_enable_strap_pin;
    strap_s2_r <= strap_s1_r;
    pdis_s1_r <= parallel_disable_strap_pin;
    pdis_s2_r <= pdis_s1_r;
  end

  // capture the straps once the synchronisers have settled after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      settle_r <= 2'h0;
      strap_done_r <= 1'b0;
      strap_serial_r <= 1'b0;
      strap_pdis_r <= 1'b0;
    end else if (!strap_done_r) begin
      settle_r <= settle_r + 2'h1;
      if (settle_r == sgmsel_pkg::STRAP_SETTLE_CYCLES) begin
        strap_done_r <= 1'b1;
        strap_serial_r <= strap_s2_r; // [R3]
        strap_pdis_r <= pdis_s2_r; // [R3]
      end
    end
  end

  // interface enable bits: strap loads serial enable, software may rewrite
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_en_r <= 1'b0;
      parallel_en_r <= sgmsel_pkg::PARALLEL_EN_RESET;
    end else if (!strap_done_r) begin
      if (settle_r == sgmsel_pkg::STRAP_SETTLE_CYCLES) begin
        serial_en_r <= strap_s2_r; // [R1]
        parallel_en_r <= !pdis_s2_r;
      end
    end else begin
      if (phy_ctrl_wr) begin
        serial_en_r <= phy_ctrl_serial_en_wdata;
      end
      if (parallel_ctrl_wr) begin
        parallel_en_r <= parallel_en_wdata;
      end
    end
  end

  // second configuration register bits
  always_ff @(posedge clk) begin
    if (rst) begin
      an_en_r <= sgmsel_pkg::AUTONEG_EN_RESET; // [R13]
      rate_adapt_r <= sgmsel_pkg::TEN_MEG_ADAPT_RESET;
    end else if (second_cfg_wr) begin
      an_en_r <= second_cfg_autoneg_wdata; // [R15]
      rate_adapt_r <= second_cfg_rate_adapt_wdata;
    end
  end

  // serial has priority over parallel
  always_comb begin
    if (serial_en_r) begin
      mode_nxt = sgmsel_pkg::SGMSEL_MODE_SERIAL; // [R2]
    end else if (parallel_en_r) begin
      mode_nxt = sgmsel_pkg::SGMSEL_MODE_PARALLEL; // [R2]
    end else begin
      mode_nxt = sgmsel_pkg::SGMSEL_MODE_NONE;
    end
  end

  // serial speed: loopback selection, else media resolution, in both an and forced modes
  always_comb begin
    if (mac_loopback) begin
      speed_nxt = loopback_speed_sel; // [R11] [R12]
    end else begin
      speed_nxt = media_res.speed; // [R10] [R14] [R16]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      speed_r <= sgmsel_pkg::SGMSEL_SPD_1000;
    end else begin
      speed_r <= speed_nxt;
    end
  end

  // auto-negotiation control word towards the mac, flagged valid only while an and serial are enabled
  always_ff @(posedge clk) begin
    if (rst) begin
      an_word_r <= 16'h0000;
    end else begin
      an_word_r <= 16'h0000;
      an_word_r[sgmsel_pkg::AN_LINK_BIT] <= media_res.link_up || mac_loopback; // [R10]
      an_word_r[sgmsel_pkg::AN_DUPLEX_BIT] <= media_res.full_duplex || mac_loopback;
      an_word_r[sgmsel_pkg::AN_SPEED_LSB +: 2] <= speed_nxt; // [R10]
      an_word_r[sgmsel_pkg::AN_ONE_BIT] <= 1'b1;
    end
  end

  // two-entry buffer; input is timed from the recovered-data byte stream, no mac clock needed
  assign in_ready = (count_r != 2'h2) && (mode == sgmsel_pkg::SGMSEL_MODE_SERIAL);
  assign push = in_valid && in_ready; // [R5]
  assign out_valid = (count_r != 2'h0); // one byte slot per clock at any speed, rate shows as repeats [R4]
  assign out_byte = buf_r[rd_ptr_r];
  assign fire = out_valid && out_ready;
  // the delimiter and gigabit bytes leave after one send, others after the speed's count
  assign last_rep = out_byte.sfd || (rep_cnt_r >= rep_limit(speed_r) - 7'h01); // [R8] [R9] [R17]
  assign pop = fire && last_rep;

  always_ff @(posedge clk) begin
    if (push) begin
      buf_r[wr_ptr_r] <= in_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_r <= !wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= !rd_ptr_r;
      end
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // repetition counter for the byte at the head of the buffer
  always_ff @(posedge clk) begin
    if (rst) begin
      rep_cnt_r <= 7'h00;
    end else if (pop) begin
      rep_cnt_r <= 7'h00;
    end else if (fire) begin
      rep_cnt_r <= rep_cnt_r + 7'h01; // [R8] [R16]
    end
  end

  // optional receive clock lane for macs without clock recovery
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_clk_r <= 1'b0;
    end else if (rx_clk_lane_cfg && serial_en_r) begin
      rx_clk_r <= !rx_clk_r; // [R7]
    end else begin
      rx_clk_r <= 1'b0;
    end
  end

  assign rx_clk_lane_out = rx_clk_r;
  assign rx_clk_lane_oe = rx_clk_lane_cfg && serial_en_r; // [R6] [R7]
  assign mode = mode_nxt;
  assign serial_enable_bit = serial_en_r;
  assign parallel_enable_bit = parallel_en_r;
  assign serial_autoneg_enable_bit = an_en_r;
  assign ten_meg_rate_adapt_bit = rate_adapt_r;
  assign strap_serial_enable = strap_serial_r;
  assign strap_parallel_disable = strap_pdis_r;
  assign serial_speed = speed_r;
  assign an_ctrl_word = an_word_r;
  assign an_ctrl_valid = an_en_r && serial_en_r;

  // checks
  sequence seq_strap_capture;
    !strap_done_r ##1 strap_done_r;
  endsequence

  sequence seq_an_clear;
    second_cfg_wr && !second_cfg_autoneg_wdata;
  endsequence

  chk_strap_load_bit: assert property (@(posedge clk) disable iff (rst) // [R1]
    seq_strap_capture |-> serial_en_r == strap_serial_r)
    else $error("serial enable bit does not match strap");

  chk_mode_priority: assert property (@(posedge clk) disable iff (rst) // [R2]
    (mode == sgmsel_pkg::SGMSEL_MODE_SERIAL) == serial_en_r
      && ((mode == sgmsel_pkg::SGMSEL_MODE_PARALLEL) == (!serial_en_r && parallel_en_r)))
    else $error("interface mode priority wrong");

  chk_strap_status_hold: assert property (@(posedge clk) disable iff (rst) // [R3]
    strap_done_r |=> $stable(strap_serial_r) && $stable(strap_pdis_r))
    else $error("strap status changed after capture");

  chk_rep_hundred: assert property (@(posedge clk) disable iff (rst) // [R8]
    pop && !out_byte.sfd && speed_r == sgmsel_pkg::SGMSEL_SPD_100 && $stable(speed_r)
      |-> rep_cnt_r == sgmsel_pkg::REP_COUNT_100 - 7'h01)
    else $error("100M byte not repeated ten times");

  chk_sfd_once: assert property (@(posedge clk) disable iff (rst) // [R9]
    fire && out_byte.sfd |-> pop)
    else $error("delimiter sent more than once");

  chk_speed_follow: assert property (@(posedge clk) disable iff (rst) // [R10] [R14]
    !mac_loopback |=> speed_r == $past(media_res.speed))
    else $error("serial speed not following media");

  chk_loopback_speed: assert property (@(posedge clk) disable iff (rst) // [R11] [R12]
    mac_loopback ##1 mac_loopback |-> speed_r == $past(loopback_speed_sel))
    else $error("loopback speed not taken from selection");

  chk_an_reset_on: assert property (@(posedge clk) // [R13]
    $fell(rst) |-> an_en_r)
    else $error("auto-negotiation off after reset");

  chk_an_disable: assert property (@(posedge clk) disable iff (rst) // [R15]
    seq_an_clear |=> !an_en_r && !an_ctrl_valid)
    else $error("auto-negotiation not disabled");

  chk_ten_auto: assert property (@(posedge clk) disable iff (rst) // [R16]
    pop && !out_byte.sfd && speed_r == sgmsel_pkg::SGMSEL_SPD_10 && $stable(speed_r)
      |-> rep_cnt_r == sgmsel_pkg::REP_COUNT_10 - 7'h01)
    else $error("10M byte not repeated automatically");

  chk_gig_once: assert property (@(posedge clk) disable iff (rst) // [R17]
    fire && speed_r == sgmsel_pkg::SGMSEL_SPD_1000 |-> pop && rep_cnt_r == 7'h00)
    else $error("gigabit byte repeated");

  chk_clk_lane_toggle: assert property (@(posedge clk) disable iff (rst) // [R7]
    rx_clk_lane_oe [*3] |-> rx_clk_lane_out != $past(rx_clk_lane_out))
    else $error("receive clock lane not toggling");

  // strap value reaches the enable bit through both synchroniser stages
  chk_strap_sync_path: assert property (@(posedge clk) disable iff (rst) // [R1]
    seq_strap_capture |-> serial_en_r == $past(serial_enable_strap_pin, 3))
    else $error("serial enable bit not taken from synchronised strap");

  chk_pdis_capture: assert property (@(posedge clk) disable iff (rst) // [R3]
    seq_strap_capture |-> strap_pdis_r == $past(parallel_disable_strap_pin, 3)
      && parallel_en_r == !strap_pdis_r)
    else $error("parallel disable strap not captured");

  sequence seq_before_capture;
    !rst && !strap_done_r && settle_r != sgmsel_pkg::STRAP_SETTLE_CYCLES;
  endsequence

  chk_early_write: assert property (@(posedge clk) disable iff (rst) // [R1]
    seq_before_capture |=> $stable(serial_en_r) && $stable(parallel_en_r))
    else $error("enable bit changed before strap capture");

  chk_in_refused: assert property (@(posedge clk) disable iff (rst) // [R2]
    (mode != sgmsel_pkg::SGMSEL_MODE_SERIAL || count_r == 2'h2) |-> !in_ready)
    else $error("byte accepted outside serial mode or into a full buffer");

  chk_byte_held: assert property (@(posedge clk) disable iff (rst) // [R8]
    !rst && out_valid && !pop |=> out_valid && $stable(out_byte))
    else $error("head byte changed before its last repetition");

  chk_lane_idle: assert property (@(posedge clk) disable iff (rst) // [R6]
    !rx_clk_lane_oe |=> !rx_clk_lane_out)
    else $error("receive clock lane active while not configured");

  // the sampled reset in the antecedent keeps the release edge out
  chk_an_word_media: assert property (@(posedge clk) disable iff (rst) // [R10]
    !rst && !mac_loopback |=> an_ctrl_word[sgmsel_pkg::AN_SPEED_LSB +: 2] == $past(media_res.speed)
      && an_ctrl_word[sgmsel_pkg::AN_ONE_BIT])
    else $error("control word speed not following media");

  chk_loopback_link: assert property (@(posedge clk) disable iff (rst) // [R12]
    !rst && mac_loopback |=> an_ctrl_word[sgmsel_pkg::AN_LINK_BIT] && an_ctrl_word[sgmsel_pkg::AN_DUPLEX_BIT])
    else $error("serial link not kept up in loopback");
endmodule

// ### design/sgmsel_pkg.sv
// Purpose: shared constants and types for the serial/parallel MAC interface selector
// Assumes: 25 MHz core clock, byte-wide model of the serial data path
// Notes: register offsets kept for reference, control bits arrive as plain ports
package sgmsel_pkg;
  // register offsets and bit positions of the documented device
  localparam logic [15:0] PHY_CONTROL_REG_OFS = 16'h0010;
  localparam int PHY_CONTROL_SERIAL_EN_BIT = 11;
  localparam logic [15:0] PARALLEL_CTRL_REG_OFS = 16'h0032;
  localparam int PARALLEL_EN_BIT = 7;
  localparam logic [15:0] SECOND_CONFIGURATION_REG_OFS = 16'h0014;
  localparam int TEN_MEG_RATE_ADAPT_BIT = 7;
  // reset values
  localparam logic AUTONEG_EN_RESET = 1'b1;
  localparam logic PARALLEL_EN_RESET = 1'b1;
  localparam logic TEN_MEG_ADAPT_RESET = 1'b1;
  // line rate in Mbit/s, fixed whatever the media speed
  localparam int SERIAL_LINE_RATE_MBPS = 1250;
  // byte repetition counts per media speed
  localparam logic [6:0] REP_COUNT_10 = 7'h64;
  localparam logic [6:0] REP_COUNT_100 = 7'h0A;
  localparam logic [6:0] REP_COUNT_1000 = 7'h01;
  // strap capture waits out the two-stage synchroniser
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;
  // auto-negotiation control word layout
  localparam int AN_LINK_BIT = 15;
  localparam int AN_DUPLEX_BIT = 12;
  localparam int AN_SPEED_LSB = 10;
  localparam int AN_ONE_BIT = 0;

  typedef enum logic [1:0] {
    SGMSEL_SPD_10 = 2'b00,
    SGMSEL_SPD_100 = 2'b01,
    SGMSEL_SPD_1000 = 2'b10
  } sgmsel_speed_e;

  typedef enum logic [1:0] {
    SGMSEL_MODE_NONE = 2'b00,
    SGMSEL_MODE_SERIAL = 2'b01,
    SGMSEL_MODE_PARALLEL = 2'b10
  } sgmsel_mode_e;

  // one frame byte; sfd marks the start-of-frame delimiter
  typedef struct packed {
    logic [7:0] data;
    logic sfd;
    logic eof;
  } sgmsel_byte_s;

  // media-side resolution
  typedef struct packed {
    logic link_up;
    logic full_duplex;
    sgmsel_speed_e speed;
  } sgmsel_media_s;
endpackage

// ### tb/sgmsel_mac_model.sv
// Purpose: behavioural mac controller taking the serial-side byte stream
// Assumes: one byte per clock at most on valid/ready
// Notes: stall_en drops ready every other cycle to exercise the buffer
`timescale 1ns/1ps
module sgmsel_mac_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall_en,
  input wire logic clr,
  input wire logic out_valid,
  output logic out_ready,
  input wire sgmsel_pkg::sgmsel_byte_s out_byte,
  output logic [7:0] data_cnt,
  output logic [7:0] sfd_cnt,
  output logic [7:0] last_data
);
  logic phase_r;
  // ready pattern; timing comes with the data, no clock of our own
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
    end
  end
  assign out_ready = !stall_en || phase_r;
  // count taken bytes; fixed line rate, so speed shows only as repeats
  always_ff @(posedge clk) begin
    if (rst || clr) begin
      data_cnt <= 8'h00;
      sfd_cnt <= 8'h00;
      last_data <= 8'h00;
    end else if (out_valid && out_ready) begin
      if (out_byte.sfd) begin
        sfd_cnt <= sfd_cnt + 8'h01;
      end else begin
        data_cnt <= data_cnt + 8'h01;
      end
      last_data <= out_byte.data;
    end
  end
endmodule

// ### tb/sgmsel_top_bench.sv
// Purpose: self-checking bench for the mac interface selector
// Assumes: straps start with serial on and parallel strap low; a second reset flips both
// Notes: inputs change on rising edges, outputs sampled on falling edges
`timescale 1ns/1ps
module sgmsel_top_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pc_wr = 1'b0, pc_d = 1'b0, pa_wr = 1'b0, pa_d = 1'b0;
  logic c2_wr = 1'b0, c2_an = 1'b1, c2_ra = 1'b1;
  logic lane_cfg = 1'b0, lpbk = 1'b0, in_valid = 1'b0, stall_en = 1'b0, clr = 1'b0;
  logic strap_se = 1'b1, strap_pd = 1'b0;
  sgmsel_pkg::sgmsel_media_s media = '{1'b1, 1'b1, sgmsel_pkg::SGMSEL_SPD_1000};
  sgmsel_pkg::sgmsel_speed_e lb_spd = sgmsel_pkg::SGMSEL_SPD_100;
  sgmsel_pkg::sgmsel_byte_s in_byte = '0;
  sgmsel_pkg::sgmsel_byte_s out_byte;
  sgmsel_pkg::sgmsel_mode_e mode;
  sgmsel_pkg::sgmsel_speed_e spd;
  logic in_ready, out_valid, out_ready, se_bit, pe_bit, an_bit, ra_bit;
  logic st_se, st_pd, an_vld, lane, lane_oe, lane_prev;
  logic [15:0] an_word;
  logic [7:0] dcnt, scnt, ldata;
  int fails = 0;
  int checked = 0;
  // free-running 25 MHz clock
  always #20 clk = ~clk;
  sgmsel_top i_dut (.clk(clk), .rst(rst), .serial_enable_strap_pin(strap_se),
    .parallel_disable_strap_pin(strap_pd), .phy_ctrl_wr(pc_wr), .phy_ctrl_serial_en_wdata(pc_d),
    .parallel_ctrl_wr(pa_wr), .parallel_en_wdata(pa_d), .second_cfg_wr(c2_wr),
    .second_cfg_autoneg_wdata(c2_an), .second_cfg_rate_adapt_wdata(c2_ra), .rx_clk_lane_cfg(lane_cfg),
    .mac_loopback(lpbk),
    .media_res(media), .loopback_speed_sel(lb_spd), .in_valid(in_valid), .in_ready(in_ready),
    .in_byte(in_byte), .out_valid(out_valid), .out_ready(out_ready), .out_byte(out_byte),
    .mode(mode), .serial_enable_bit(se_bit), .parallel_enable_bit(pe_bit),
    .serial_autoneg_enable_bit(an_bit), .ten_meg_rate_adapt_bit(ra_bit),
    .strap_serial_enable(st_se), .strap_parallel_disable(st_pd), .serial_speed(spd),
    .an_ctrl_word(an_word), .an_ctrl_valid(an_vld), .rx_clk_lane_out(lane),
    .rx_clk_lane_oe(lane_oe));
  sgmsel_mac_model i_mac (.clk(clk), .rst(rst), .stall_en(stall_en), .clr(clr),
    .out_valid(out_valid), .out_ready(out_ready), .out_byte(out_byte), .data_cnt(dcnt),
    .sfd_cnt(scnt), .last_data(ldata));
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one config write: 0 phy control, 1 parallel control, 2 second config
  task automatic wr(input logic [1:0] sel, input logic d);
    @(posedge clk);
    pc_wr <= (sel == 2'h0);
    pa_wr <= (sel == 2'h1);
    c2_wr <= (sel == 2'h2);
    pc_d <= d;
    pa_d <= d;
    c2_an <= d;
    @(posedge clk);
    pc_wr <= 1'b0;
    pa_wr <= 1'b0;
    c2_wr <= 1'b0;
    @(negedge clk);
  endtask
  // push one byte, holding it until ready was seen
  task automatic send(input logic sfd, input logic [7:0] d);
    int n;
    @(posedge clk);
    in_valid <= 1'b1;
    in_byte <= '{d, sfd, 1'b0};
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (in_ready !== 1'b1 && n < 100);
    chk({15'h0000, in_ready}, 16'h0001);
    @(posedge clk);
    in_valid <= 1'b0;
  endtask
  // delimiter plus one data byte, then count what the mac took
  task automatic rep(input sgmsel_pkg::sgmsel_speed_e s, input logic [7:0] n);
    int w;
    @(posedge clk);
    media <= '{1'b1, 1'b1, s};
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    send(1'b1, 8'hD5);
    send(1'b0, 8'h5A);
    w = 0;
    do begin
      @(negedge clk);
      w++;
    end while (out_valid !== 1'b0 && w < 1000);
    chk({15'h0000, out_valid}, 16'h0000);
    chk({8'h00, scnt}, 16'h0001);
    chk({8'h00, dcnt}, {8'h00, n});
    chk({8'h00, ldata}, 16'h005A);
    $display("stream test done at speed %0d", s);
  endtask
  // verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // watchdog, tests need about 320 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    summarize();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk({10'h000, se_bit, pe_bit, an_bit, ra_bit, st_se, st_pd}, 16'h003E);
    chk({13'h0000, mode, in_ready}, 16'h0003);
    wr(2'h0, 1'b0);
    chk({13'h0000, mode, in_ready}, 16'h0004);
    wr(2'h1, 1'b0);
    wr(2'h0, 1'b1);
    chk({14'h0000, mode}, 16'h0001);
    wr(2'h1, 1'b1);
    chk({14'h0000, mode}, 16'h0001);
    $display("mode test done");
    rep(sgmsel_pkg::SGMSEL_SPD_1000, 8'h01);
    @(posedge clk);
    stall_en <= 1'b1;
    rep(sgmsel_pkg::SGMSEL_SPD_100, 8'h0A);
    @(posedge clk);
    c2_ra <= 1'b0;
    wr(2'h2, 1'b1);
    rep(sgmsel_pkg::SGMSEL_SPD_10, 8'h64);
    chk({14'h0000, ra_bit, an_vld}, 16'h0001);
    chk(an_word, 16'h9001);
    @(posedge clk);
    media <= '{1'b1, 1'b1, sgmsel_pkg::SGMSEL_SPD_100};
    repeat (2) @(negedge clk);
    chk(an_word, 16'h9401);
    wr(2'h2, 1'b0);
    chk({13'h0000, an_bit, an_vld, 1'b0}, 16'h0000);
    chk({14'h0000, spd}, 16'h0001);
    @(posedge clk);
    media <= '{1'b1, 1'b0, sgmsel_pkg::SGMSEL_SPD_1000};
    repeat (2) @(negedge clk);
    chk({14'h0000, spd}, 16'h0002);
    $display("autoneg test done");
    @(posedge clk);
    lpbk <= 1'b1;
    media <= '{1'b0, 1'b0, sgmsel_pkg::SGMSEL_SPD_10};
    wr(2'h2, 1'b1);
    repeat (2) @(negedge clk);
    chk({14'h0000, spd}, 16'h0001);
    chk(an_word, 16'h9401);
    wr(2'h2, 1'b0);
    rep(sgmsel_pkg::SGMSEL_SPD_1000, 8'h0A);
    @(posedge clk);
    lpbk <= 1'b0;
    @(negedge clk);
    chk({15'h0000, lane_oe}, 16'h0000);
    @(posedge clk);
    lane_cfg <= 1'b1;
    repeat (2) @(negedge clk);
    lane_prev = lane;
    @(negedge clk);
    chk({14'h0000, lane_oe, lane ^ lane_prev}, 16'h0003);
    @(posedge clk);
    lane_cfg <= 1'b0;
    repeat (2) @(negedge clk);
    chk({15'h0000, lane_oe}, 16'h0000);
    $display("clock lane test done");
    // second reset with flipped straps: serial off, parallel disabled, no interface selected
    @(posedge clk);
    strap_se <= 1'b0;
    strap_pd <= 1'b1;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk({10'h000, se_bit, pe_bit, an_bit, ra_bit, st_se, st_pd}, 16'h000D);
    chk({13'h0000, mode, in_ready}, 16'h0000);
    $display("strap reset test done");
    summarize();
  end
endmodule
